// [src/swr_top.v]
`timescale 1ns/1ps
`include "swr_consts.vh"

module swr_top (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        large_memory_in,
  input  wire        sleep_exec_in,
  input  wire        wdt_enable_in,
  input  wire        wdt_overflow_in,
  input  wire        master_clear_n_in,
  input  wire        brownout_in,
  input  wire [7:0]  port_b_in,
  input  wire        cfg_write_in,
  input  wire [7:0]  mode_in,
  input  wire [7:0]  accum_in,
  output wire        reset_n_out,
  output wire        core_run_out,
  output wire        irq_out,
  output wire        timeout_flag_out,
  output wire        powerdown_flag_out,
  output wire        pc_load_out,
  output wire [11:0] pc_value_out,
  output wire        accum_load_out,
  output wire [7:0]  accum_data_out,
  output wire [7:0]  port_b_dir_out,
  output wire [7:0]  wake_enable_out,
  output wire [7:0]  comparator_control_out
);

  localparam integer               HOLD_LAST_I = `SWR_RESET_HOLD_CYC - 1;
  localparam [`SWR_HOLD_CNT_W-1:0] HOLD_LAST   = HOLD_LAST_I[`SWR_HOLD_CNT_W-1:0];

  // synchronised pins: master clear idles high, others low
  wire [10:0] sync_w;
  wire [7:0]  pin_s;
  wire        master_clear_n_n_s;
  wire        brown_s;
  wire        wdt_s;

  swr_pin_sync #(
    .RESET_VAL (11'h100)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .raw_in      ({wdt_overflow_in, brownout_in, master_clear_n_in, port_b_in}),
    .stable_out  (sync_w)
  );

  assign pin_s    = sync_w[7:0];
  assign master_clear_n_n_s = sync_w[8];
  assign brown_s  = sync_w[9];
  assign wdt_s    = sync_w[10];

  reg [2:0]                 state_reg;
  reg [2:0]                 state_next;
  reg [`SWR_HOLD_CNT_W-1:0] hold_reg;
  reg [`SWR_HOLD_CNT_W-1:0] hold_next;
  reg                       large_reg;
  reg [7:0]                 pin_prev_reg;
  reg                       wdt_prev_reg;
  reg [7:0]                 dir_reg;
  reg [7:0]                 dir_next;
  reg [7:0]                 edge_reg;
  reg [7:0]                 edge_next;
  reg [7:0]                 wken_reg;
  reg [7:0]                 wken_next;
  reg [7:0]                 pend_reg;
  reg [7:0]                 pend_next;
  reg [7:0]                 cmp_reg;
  reg [7:0]                 cmp_next;
  reg                       to_reg;
  reg                       to_next;
  reg                       pd_reg;
  reg                       pd_next;
  reg                       reset_n_reg;
  reg                       reset_n_next;
  reg                       run_reg;
  reg                       run_next;
  reg                       irq_reg;
  reg                       irq_next;
  reg                       pc_load_reg;
  reg                       pc_load_next;
  reg [11:0]                pc_value_reg;
  reg [11:0]                pc_value_next;
  reg                       acc_load_reg;
  reg                       acc_load_next;
  reg [7:0]                 acc_data_reg;
  reg [7:0]                 acc_data_next;

  // edge detection runs on the free-running block clock, independent
  // of the core's halted clock, so no wakeup edge is lost asleep
  wire [7:0] rise_w;
  wire [7:0] fall_w;
  wire [7:0] hit_w;
  genvar     p;
  generate
    for (p = 0; p < 8; p = p + 1) begin : g_pin
      assign rise_w[p] = pin_s[p] & ~pin_prev_reg[p];
      assign fall_w[p] = ~pin_s[p] & pin_prev_reg[p];
      // a disabled pin never qualifies, whatever its polarity bit says
      assign hit_w[p]  = ~wken_reg[p] &
                         (edge_reg[p] ? fall_w[p] : rise_w[p]);
    end
  endgenerate
  // an already pending pin gives no new event until cleared
  wire [7:0] new_hit_w = hit_w & ~pend_reg;
  wire       wdt_evt_w = wdt_s & ~wdt_prev_reg;
  wire       master_clear_n_w    = ~master_clear_n_n_s;
  wire [11:0] top_w    = large_reg ? `SWR_TOP_ADDR_LARGE : `SWR_TOP_ADDR_SMALL;
  wire       cfg_ok_w  = cfg_write_in & state_reg[0];

  always @* begin
    state_next    = state_reg;
    hold_next     = hold_reg;
    dir_next      = dir_reg;
    edge_next     = edge_reg;
    wken_next     = wken_reg;
    pend_next     = pend_reg;
    cmp_next      = cmp_reg;
    to_next       = to_reg;
    pd_next       = pd_reg;
    reset_n_next  = reset_n_reg;
    run_next      = run_reg;
    irq_next      = 1'b0;
    pc_load_next  = 1'b0;
    pc_value_next = pc_value_reg;
    acc_load_next = 1'b0;
    acc_data_next = acc_data_reg;

    // port-configuration write, target chosen by the mode selector
    if (cfg_ok_w) begin
      case (mode_in)
        `SWR_MODE_DIR: begin
          dir_next = accum_in;
        end
        `SWR_MODE_EDGE: begin
          edge_next = accum_in;
        end
        `SWR_MODE_WKEN: begin
          wken_next = accum_in;
        end
        `SWR_MODE_PEND: begin
          pend_next     = accum_in;
          acc_data_next = pend_reg;
          acc_load_next = 1'b1;
        end
        `SWR_MODE_CMP: begin
          cmp_next      = accum_in;
          acc_data_next = cmp_reg;
          acc_load_next = 1'b1;
        end
        default: begin
          acc_load_next = 1'b0;
        end
      endcase
    end

    // hardware set wins over a same-cycle software clear
    pend_next = pend_next | hit_w;

    case (state_reg)
      `SWR_ST_RUN: begin
        if (master_clear_n_w || brown_s || (wdt_evt_w && wdt_enable_in)) begin
          state_next   = `SWR_ST_RST;
          hold_next    = {`SWR_HOLD_CNT_W{1'b0}};
          reset_n_next = 1'b0;
          run_next     = 1'b0;
          if (wdt_evt_w && wdt_enable_in && !master_clear_n_w && !brown_s) begin
            to_next = 1'b0;
            pd_next = 1'b1;
          end
        end else if (sleep_exec_in) begin
          state_next = `SWR_ST_SLEEP;
          run_next   = 1'b0;
          pd_next    = 1'b0;
          if (wdt_enable_in) begin
            to_next = 1'b1;
          end
        end else begin
          // level request while any armed pin is pending
          irq_next = |(pend_next & ~wken_reg);
          if (irq_next && !irq_reg) begin
            // core saves its context, then fetches from the vector
            pc_load_next  = 1'b1;
            pc_value_next = `SWR_INT_VECTOR;
          end
        end
      end
      `SWR_ST_SLEEP: begin
        if ((wdt_evt_w && wdt_enable_in) || (|new_hit_w) ||
            master_clear_n_w || brown_s) begin
          state_next   = `SWR_ST_RST;
          hold_next    = {`SWR_HOLD_CNT_W{1'b0}};
          reset_n_next = 1'b0;
          to_next      = 1'b1;
          pd_next      = 1'b1;
        end
      end
      `SWR_ST_RST: begin
        // direction, edge and enable masks return to all-ones on every reset, comparator control to SWR_CMP_RST
        dir_next  = `SWR_DIR_RST;
        edge_next = `SWR_EDGE_RST;
        wken_next = `SWR_WKEN_RST;
        cmp_next  = `SWR_CMP_RST;
        // held low while a cause persists, then counted out
        if (master_clear_n_w || brown_s) begin
          hold_next = {`SWR_HOLD_CNT_W{1'b0}};
        end else if (hold_reg == HOLD_LAST) begin
          state_next    = `SWR_ST_RUN;
          reset_n_next  = 1'b1;
          run_next      = 1'b1;
          pc_load_next  = 1'b1;
          pc_value_next = top_w;
        end else begin
          hold_next = hold_reg + 1'b1;
        end
      end
      default: begin
        state_next   = `SWR_ST_RST;
        hold_next    = {`SWR_HOLD_CNT_W{1'b0}};
        reset_n_next = 1'b0;
        run_next     = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      // power-up reset enters the same hold sequence
      state_reg    <= `SWR_ST_RST;
      hold_reg     <= {`SWR_HOLD_CNT_W{1'b0}};
      pin_prev_reg <= 8'h00;
      wdt_prev_reg <= 1'b0;
      dir_reg      <= `SWR_DIR_RST;
      edge_reg     <= `SWR_EDGE_RST;
      wken_reg     <= `SWR_WKEN_RST;
      pend_reg     <= `SWR_PEND_RST;
      cmp_reg      <= `SWR_CMP_RST;
      to_reg       <= 1'b1;
      pd_reg       <= 1'b1;
      reset_n_reg  <= 1'b0;
      run_reg      <= 1'b0;
      irq_reg      <= 1'b0;
      pc_load_reg  <= 1'b0;
      pc_value_reg <= 12'h000;
      acc_load_reg <= 1'b0;
      acc_data_reg <= 8'h00;
    end else begin
      state_reg    <= state_next;
      hold_reg     <= hold_next;
      pin_prev_reg <= pin_s;
      wdt_prev_reg <= wdt_s;
      dir_reg      <= dir_next;
      edge_reg     <= edge_next;
      wken_reg     <= wken_next;
      pend_reg     <= pend_next;
      cmp_reg      <= cmp_next;
      to_reg       <= to_next;
      pd_reg       <= pd_next;
      reset_n_reg  <= reset_n_next;
      run_reg      <= run_next;
      irq_reg      <= irq_next;
      pc_load_reg  <= pc_load_next;
      pc_value_reg <= pc_value_next;
      acc_load_reg <= acc_load_next;
      acc_data_reg <= acc_data_next;
    end
  end

  // variant strap sampled while the power-up reset is held
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      large_reg <= large_memory_in;
    end
  end

  assign reset_n_out            = reset_n_reg;
  assign core_run_out           = run_reg;
  assign irq_out                = irq_reg;
  assign timeout_flag_out       = to_reg;
  assign powerdown_flag_out     = pd_reg;
  assign pc_load_out            = pc_load_reg;
  assign pc_value_out           = pc_value_reg;
  assign accum_load_out         = acc_load_reg;
  assign accum_data_out         = acc_data_reg;
  assign port_b_dir_out         = dir_reg;
  assign wake_enable_out        = wken_reg;
  assign comparator_control_out = cmp_reg;

endmodule

// [src/swr_consts.vh]
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH

// mode selector codes for the port-configuration write
`define SWR_MODE_DIR        8'h0F
`define SWR_MODE_EDGE       8'h0A
`define SWR_MODE_PEND       8'h09
`define SWR_MODE_WKEN       8'h0B
`define SWR_MODE_CMP        8'h08

// reset values
`define SWR_DIR_RST         8'hFF
`define SWR_EDGE_RST        8'hFF
`define SWR_WKEN_RST        8'hFF
`define SWR_PEND_RST        8'h00
`define SWR_CMP_RST         8'hC1

// program addresses
`define SWR_TOP_ADDR_SMALL  12'h7FF
`define SWR_TOP_ADDR_LARGE  12'hFFF
`define SWR_INT_VECTOR      12'h000

// internal reset hold time
`define SWR_CLK_PERIOD_NS   25
`define SWR_RESET_HOLD_NS   1000
`define SWR_RESET_HOLD_CYC  ((`SWR_RESET_HOLD_NS + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)
`define SWR_HOLD_CNT_W      6

// state codes, one-hot
`define SWR_ST_RUN          3'b001
`define SWR_ST_SLEEP        3'b010
`define SWR_ST_RST          3'b100

`endif

// [src/swr_pin_sync.v]
`timescale 1ns/1ps
`include "swr_consts.vh"

// three-stage synchroniser per bit; output moves only once stages 2 and 3 agree
module swr_pin_sync #(
  parameter [10:0] RESET_VAL = 11'h000
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire [10:0] raw_in,
  output wire [10:0] stable_out
);

  genvar i;
  generate
    for (i = 0; i < 11; i = i + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg stable_reg;
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          s1_reg     <= RESET_VAL[i];
          s2_reg     <= RESET_VAL[i];
          s3_reg     <= RESET_VAL[i];
          stable_reg <= RESET_VAL[i];
        end else begin
          s1_reg <= raw_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // first stage is never looked at here, only stage 2 against stage 3
          if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
          end
        end
      end
      assign stable_out[i] = stable_reg;
    end
  endgenerate

endmodule

// [verification/swr_ext_model.sv]
`timescale 1ns/1ps

// pins, watchdog and supply monitor as seen from outside the block
module swr_ext_model (
  input  wire logic       core_clk_in,
  output logic      [7:0] port_b_out,
  output logic            wdt_overflow_out,
  output logic            master_clear_n_out,
  output logic            brownout_out
);
  // pin 0 starts low so a rising edge can be made later
  initial begin
    port_b_out = 8'hFE;
    wdt_overflow_out = 1'b0;
    master_clear_n_out = 1'b1;
    brownout_out = 1'b0;
  end

  task set_pins(input logic [7:0] v);
    port_b_out = v;
  endtask

  // cause 0 drops pin 1, others pulse a wake source for 6 cycles
  task fire(input integer c);
    begin
      if (c == 0) begin
        port_b_out = 8'hFD;
      end else begin
        wdt_overflow_out = (c == 1);
        master_clear_n_out = (c != 2);
        brownout_out = (c == 3);
        repeat (6) @(negedge core_clk_in);
        wdt_overflow_out = 1'b0;
        master_clear_n_out = 1'b1;
        brownout_out = 1'b0;
      end
    end
  endtask
endmodule

// [verification/swr_top_sva.sv]
`timescale 1ns/1ps
`include "swr_consts.vh"

module swr_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        large_memory_in,
  input wire logic        sleep_exec_in,
  input wire logic        wdt_enable_in,
  input wire logic        cfg_write_in,
  input wire logic [7:0]  mode_in,
  input wire logic [7:0]  accum_in,
  input wire logic        reset_n_out,
  input wire logic        core_run_out,
  input wire logic        irq_out,
  input wire logic        timeout_flag_out,
  input wire logic        powerdown_flag_out,
  input wire logic        pc_load_out,
  input wire logic [11:0] pc_value_out,
  input wire logic        accum_load_out,
  input wire logic [7:0]  port_b_dir_out,
  input wire logic [7:0]  wake_enable_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_run;
    reset_n_out && core_run_out;
  endsequence
  sequence s_wr(m);
    s_run ##0 (cfg_write_in && mode_in == m);
  endsequence

  a_rst_state: assert property ($fell(rst_in) |-> !reset_n_out && !core_run_out
    && wake_enable_out == `SWR_WKEN_RST && port_b_dir_out == `SWR_DIR_RST)
    else $error("state wrong as reset ends");
  a_hold_low: assert property ($fell(reset_n_out) |=> !reset_n_out [*8])
    else $error("internal reset too short");
  a_release_top: assert property ($rose(reset_n_out) |-> pc_load_out && pc_value_out ==
    (large_memory_in ? `SWR_TOP_ADDR_LARGE : `SWR_TOP_ADDR_SMALL))
    else $error("restart not at top address");
  a_wake_flags: assert property ($fell(reset_n_out) && !$past(core_run_out) |->
    timeout_flag_out && powerdown_flag_out)
    else $error("wake flags not both set");
  a_sleep_flags: assert property (s_run ##0 (sleep_exec_in && wdt_enable_in) |=>
    !core_run_out && timeout_flag_out && !powerdown_flag_out)
    else $error("sleep entry wrong");
  a_irq_vector: assert property ($rose(irq_out) |-> pc_load_out
    && pc_value_out == `SWR_INT_VECTOR)
    else $error("interrupt vector wrong");
  a_swap_pulse: assert property (s_run ##0 (cfg_write_in && (mode_in == `SWR_MODE_PEND
    || mode_in == `SWR_MODE_CMP)) |=> accum_load_out)
    else $error("swap gave no load pulse");
  a_quiet_load: assert property (!cfg_write_in |=> !accum_load_out)
    else $error("load pulse without write");
  a_dir_write: assert property (s_wr(`SWR_MODE_DIR) |=> port_b_dir_out == $past(accum_in))
    else $error("direction write lost");
  a_wken_write: assert property (s_wr(`SWR_MODE_WKEN) |=> wake_enable_out == $past(accum_in))
    else $error("enable write lost");
endmodule

bind swr_top swr_chk u_chk (
  .core_clk_in        (core_clk_in),
  .rst_in             (rst_in),
  .large_memory_in    (large_memory_in),
  .sleep_exec_in      (sleep_exec_in),
  .wdt_enable_in      (wdt_enable_in),
  .cfg_write_in       (cfg_write_in),
  .mode_in            (mode_in),
  .accum_in           (accum_in),
  .reset_n_out        (reset_n_out),
  .core_run_out       (core_run_out),
  .irq_out            (irq_out),
  .timeout_flag_out   (timeout_flag_out),
  .powerdown_flag_out (powerdown_flag_out),
  .pc_load_out        (pc_load_out),
  .pc_value_out       (pc_value_out),
  .accum_load_out     (accum_load_out),
  .port_b_dir_out     (port_b_dir_out),
  .wake_enable_out    (wake_enable_out)
);

// [verification/tb.sv]
`timescale 1ns/1ps
`include "swr_consts.vh"

module tb;
  logic        core_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        large_memory_in = 1'b0;
  logic        sleep_exec_in = 1'b0;
  logic        wdt_enable_in = 1'b1;
  logic        cfg_write_in = 1'b0;
  logic [7:0]  mode_in = 8'h00;
  logic [7:0]  accum_in = 8'h00;
  logic        wdt_overflow_in, master_clear_n_in, brownout_in;
  logic [7:0]  port_b_in, accum_data_out, port_b_dir_out, wake_enable_out;
  logic [7:0]  comparator_control_out;
  logic [11:0] pc_value_out;
  logic        reset_n_out, core_run_out, irq_out, timeout_flag_out;
  logic        powerdown_flag_out, pc_load_out, accum_load_out;
  integer      fails = 0;
  integer      samples_checked = 0;
  logic [11:0] top_exp = `SWR_TOP_ADDR_SMALL;

  always #12.5 core_clk_in = ~core_clk_in;

  swr_top u_dut (
    .core_clk_in            (core_clk_in),
    .rst_in                 (rst_in),
    .large_memory_in        (large_memory_in),
    .sleep_exec_in          (sleep_exec_in),
    .wdt_enable_in          (wdt_enable_in),
    .wdt_overflow_in        (wdt_overflow_in),
    .master_clear_n_in      (master_clear_n_in),
    .brownout_in            (brownout_in),
    .port_b_in              (port_b_in),
    .cfg_write_in           (cfg_write_in),
    .mode_in                (mode_in),
    .accum_in               (accum_in),
    .reset_n_out            (reset_n_out),
    .core_run_out           (core_run_out),
    .irq_out                (irq_out),
    .timeout_flag_out       (timeout_flag_out),
    .powerdown_flag_out     (powerdown_flag_out),
    .pc_load_out            (pc_load_out),
    .pc_value_out           (pc_value_out),
    .accum_load_out         (accum_load_out),
    .accum_data_out         (accum_data_out),
    .port_b_dir_out         (port_b_dir_out),
    .wake_enable_out        (wake_enable_out),
    .comparator_control_out (comparator_control_out)
  );
  swr_ext_model u_ext (
    .core_clk_in        (core_clk_in),
    .port_b_out         (port_b_in),
    .wdt_overflow_out   (wdt_overflow_in),
    .master_clear_n_out (master_clear_n_in),
    .brownout_out       (brownout_in)
  );

  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  task check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task chk1(input logic s, input logic e);
    check({11'h000, s}, {11'h000, e});
  endtask

  task clk(input integer n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // bounded so a stuck design ends the run instead of hanging it
  task wait_sig(input integer sel, input logic lvl);
    integer i;
    begin
      i = 0;
      while (((sel == 0) ? reset_n_out : irq_out) !== lvl && i < 100) begin
        clk(1);
        i = i + 1;
      end
      if (i == 100) begin
        fails = fails + 1;
        $display("mismatch at %0t: wait ran out", $time);
        final_report;
      end
    end
  endtask

  // one idle edge first, so back-to-back writes never retoggle the strobe in one step
  task cfg(input logic [7:0] m, input logic [7:0] a);
    clk(1);
    cfg_write_in = 1'b1;
    mode_in = m;
    accum_in = a;
    clk(1);
    cfg_write_in = 1'b0;
  endtask

  task swap(input logic [7:0] m, input logic [7:0] a, input logic [7:0] old);
    cfg(m, a);
    chk1(accum_load_out, 1'b1);
    check({4'h0, accum_data_out}, {4'h0, old});
  endtask

  task t_reset;
    check({4'h0, wake_enable_out}, {4'h0, `SWR_WKEN_RST});
    check({4'h0, comparator_control_out}, {4'h0, `SWR_CMP_RST});
    chk1(reset_n_out, 1'b0);
    rst_in = 1'b0;
    wait_sig(0, 1'b1);
    chk1(pc_load_out, 1'b1);
    check(pc_value_out, `SWR_TOP_ADDR_SMALL);
  endtask

  // software order: direction and edge, then clear pending, enable mask last
  task t_config;
    cfg(`SWR_MODE_DIR, 8'h03);
    check({4'h0, port_b_dir_out}, 12'h003);
    cfg(`SWR_MODE_EDGE, 8'h02);
    swap(`SWR_MODE_PEND, 8'h00, 8'h00);
    swap(`SWR_MODE_CMP, 8'h5A, `SWR_CMP_RST);
    swap(`SWR_MODE_CMP, 8'hA5, 8'h5A);
    check({4'h0, comparator_control_out}, 12'h0A5);
    cfg(8'h07, 8'h00);
    chk1(accum_load_out, 1'b0);
    check({4'h0, port_b_dir_out}, 12'h003);
    cfg(`SWR_MODE_WKEN, 8'hFC);
    check({4'h0, wake_enable_out}, 12'h0FC);
  endtask

  // disabled pins 2-7 fall and then rise with pin 0; only pin 0 may pend
  task t_irq;
    u_ext.set_pins(8'h02);
    clk(6);
    chk1(irq_out, 1'b0);
    u_ext.set_pins(8'hFF);
    wait_sig(1, 1'b1);
    check(pc_value_out, `SWR_INT_VECTOR);
    clk(5);
    chk1(irq_out, 1'b1);
    swap(`SWR_MODE_PEND, 8'h00, 8'h01);
    wait_sig(1, 1'b0);
  endtask

  task t_sleep(input integer c);
    sleep_exec_in = 1'b1;
    clk(1);
    sleep_exec_in = 1'b0;
    chk1(core_run_out, 1'b0);
    chk1(timeout_flag_out, 1'b1);
    chk1(powerdown_flag_out, 1'b0);
    clk(10);
    chk1(reset_n_out, 1'b1);
    u_ext.fire(c);
    wait_sig(0, 1'b0);
    chk1(timeout_flag_out, 1'b1);
    chk1(powerdown_flag_out, 1'b1);
    wait_sig(0, 1'b1);
    chk1(pc_load_out, 1'b1);
    check(pc_value_out, top_exp);
    check({4'h0, wake_enable_out}, {4'h0, `SWR_WKEN_RST});
  endtask

  // watchdog off: its overflow must not wake the sleeping core
  task t_wdt_off;
    wdt_enable_in = 1'b0;
    sleep_exec_in = 1'b1;
    clk(1);
    sleep_exec_in = 1'b0;
    chk1(powerdown_flag_out, 1'b0);
    u_ext.fire(1);
    clk(4);
    chk1(reset_n_out, 1'b1);
    chk1(core_run_out, 1'b0);
    wdt_enable_in = 1'b1;
    u_ext.fire(2);
    wait_sig(0, 1'b1);
    chk1(pc_load_out, 1'b1);
    check(pc_value_out, top_exp);
  endtask

  // second power-up reset in mid-run, now with the large-memory strap
  task t_reset_large;
    large_memory_in = 1'b1;
    top_exp = `SWR_TOP_ADDR_LARGE;
    rst_in = 1'b1;
    clk(8);
    chk1(reset_n_out, 1'b0);
    check({4'h0, port_b_dir_out}, {4'h0, `SWR_DIR_RST});
    rst_in = 1'b0;
    wait_sig(0, 1'b1);
    chk1(pc_load_out, 1'b1);
    check(pc_value_out, top_exp);
  endtask

  initial begin
    clk(8);
    t_reset;
    t_config;
    t_irq;
    for (int c = 0; c < 4; c++) begin
      t_sleep(c);
    end
    t_wdt_off;
    t_reset_large;
    t_sleep(3);
    final_report;
  end
endmodule
